// File: logic/arc_pkg.sv
// constants and types for the angular-rate configuration registers
package arc_pkg;
    localparam logic [7:0] ARC_ADDR_IDENTITY  = 8'h0f;
    localparam logic [7:0] ARC_ADDR_CTRL1     = 8'h20;
    localparam logic [7:0] ARC_ADDR_CTRL2     = 8'h21;
    localparam logic [7:0] ARC_ADDR_FILT_EN   = 8'h24;
    localparam logic [7:0] ARC_ADDR_REFERENCE = 8'h25;

    localparam logic [7:0] ARC_RST_CTRL1      = 8'h07;
    localparam logic [7:0] ARC_RST_CTRL2      = 8'h00;
    localparam logic       ARC_RST_HP_ON      = 1'b0;
    localparam logic [7:0] ARC_RST_REFERENCE  = 8'h00;
    localparam logic [7:0] ARC_UNMAPPED_READ  = 8'h00;

    // field positions, control register one
    localparam int ARC_RATE_MSB = 7;
    localparam int ARC_RATE_LSB = 6;
    localparam int ARC_BAND_MSB = 5;
    localparam int ARC_BAND_LSB = 4;
    localparam int ARC_PWR_BIT = 3;
    localparam int ARC_ZEN_BIT = 2;
    localparam int ARC_XEN_BIT = 1;
    localparam int ARC_YEN_BIT = 0;
    // field positions, control register two
    localparam int ARC_EDGE_BIT = 7;
    localparam int ARC_LVL_BIT  = 6;
    localparam int ARC_HPTYPE_MSB = 5;
    localparam int ARC_HPTYPE_LSB = 4;
    localparam int ARC_CORNER_MSB = 3;
    localparam int ARC_CORNER_LSB = 0;
    // field position, filter enable register
    localparam int ARC_HPON_BIT = 4;

    localparam logic [1:0] ARC_HPTYPE_NORMAL_RST = 2'h0;
    localparam logic [1:0] ARC_HPTYPE_REFERENCE  = 2'h1;
    localparam logic [1:0] ARC_HPTYPE_NORMAL     = 2'h2;
    localparam logic [1:0] ARC_HPTYPE_AUTORESET  = 2'h3;
    localparam logic [3:0] ARC_CORNER_MAX        = 4'h9;

    // timing: base sample rate and clock
    localparam int ARC_CLK_HZ      = 125000000;
    localparam int ARC_BASE_ODR_HZ = 95;
    localparam int ARC_BASE_DIV    = ARC_CLK_HZ / ARC_BASE_ODR_HZ;

    typedef enum logic [1:0] {
        PWR_DOWN,
        PWR_SLEEP,
        PWR_NORMAL
    } arc_pwr_t;
endpackage

// File: logic/arc_cfg_if.sv
// configuration carried from the register file to its helpers
`timescale 1ns/1ps
interface arc_cfg_if;
    logic [7:0] ctrl1;     // rate, band, power, axis enables
    logic [7:0] ctrl2;     // triggers, high-pass type and corner
    logic       hp_on;     // high-pass enable
    logic       ref_read;  // pulse: reference register read

    modport regs (output ctrl1, output ctrl2, output hp_on,
                  output ref_read);
    modport user (input ctrl1, input ctrl2, input hp_on,
                  input ref_read);
endinterface

// File: logic/arc_rate_timing.sv
// power mode, axis gating, sample timing and low-pass cutoff
`timescale 1ns/1ps
module arc_rate_timing
    import arc_pkg::*;
#(
    parameter int BASE_DIV = ARC_BASE_DIV
) (
    input  wire logic   i_mclk,            // system clock
    input  wire logic   i_reset,           // async reset, high
    arc_cfg_if.user     cfg,               // configuration
    input  wire logic   i_trig_pin,        // external trigger pin
    output arc_pwr_t    o_power_mode,      // registered mode
    output logic [2:0]  o_axis_on,         // z,x,y measuring
    output logic        o_sample_strobe,   // one pulse per sample
    output logic [9:0]  o_cutoff_dhz       // low-pass, 0.1 Hz units
);
    if (BASE_DIV < 16 || BASE_DIV > 16777215) begin : g_bad_div
        $error("BASE_DIV out of range");
    end

    arc_pwr_t    mode_next;
    logic [2:0]  axis_next;
    logic        strobe_next;
    logic [9:0]  cutoff_next;
    logic [23:0] cnt_reg;
    logic [23:0] cnt_next;
    logic [23:0] period;
    logic        pin_reg;
    logic        tick;
    logic [1:0]  rate_code;

    function automatic logic [9:0] lp_cutoff(input logic [3:0] sel);
        unique case (sel)
            4'h0, 4'h4:             lp_cutoff = 10'd125;
            4'h1, 4'h2, 4'h3, 4'h5,
            4'h9:                   lp_cutoff = 10'd250;
            4'h6, 4'ha, 4'he:       lp_cutoff = 10'd500;
            4'h7:                   lp_cutoff = 10'd700;
            4'h8:                   lp_cutoff = 10'd200;
            4'hc:                   lp_cutoff = 10'd300;
            4'hd:                   lp_cutoff = 10'd350;
            4'hb, 4'hf:             lp_cutoff = 10'd1000;
        endcase
    endfunction

    always_comb begin
        rate_code = cfg.ctrl1[ARC_RATE_MSB:ARC_RATE_LSB];
        period = 24'(BASE_DIV) >> rate_code;
        tick = (cnt_reg >= period - 24'h1);
        if (!cfg.ctrl1[ARC_PWR_BIT])
            mode_next = PWR_DOWN;
        else if (cfg.ctrl1[ARC_ZEN_BIT:ARC_YEN_BIT] == 3'h0)
            mode_next = PWR_SLEEP;
        else
            mode_next = PWR_NORMAL;
        axis_next = (mode_next == PWR_NORMAL) ?
                    cfg.ctrl1[ARC_ZEN_BIT:ARC_YEN_BIT] : 3'h0;
        cnt_next = (mode_next != PWR_NORMAL || tick) ? 24'h0
                                                     : cnt_reg + 24'h1;
        if (mode_next != PWR_NORMAL)
            strobe_next = 1'b0;
        else if (cfg.ctrl2[ARC_EDGE_BIT])
            strobe_next = i_trig_pin && !pin_reg;
        else if (cfg.ctrl2[ARC_LVL_BIT])
            strobe_next = tick && i_trig_pin;
        else
            strobe_next = tick;
        cutoff_next =
            lp_cutoff(cfg.ctrl1[ARC_RATE_MSB:ARC_BAND_LSB]);
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_power_mode    <= PWR_DOWN;
            o_axis_on       <= 3'h0;
            o_sample_strobe <= 1'b0;
            o_cutoff_dhz    <= 10'd125;
            cnt_reg         <= 24'h0;
            pin_reg         <= 1'b0;
        end else begin
            o_power_mode    <= mode_next;
            o_axis_on       <= axis_next;
            o_sample_strobe <= strobe_next;
            o_cutoff_dhz    <= cutoff_next;
            cnt_reg         <= cnt_next;
            pin_reg         <= i_trig_pin;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    chk_down_no_strobe: assert property (
        !cfg.ctrl1[ARC_PWR_BIT] |=> !o_sample_strobe && o_axis_on == 3'h0)
        else $error("strobe or axis active in power-down");
    chk_sleep_mode: assert property (
        cfg.ctrl1[ARC_PWR_BIT] && cfg.ctrl1[2:0] == 3'h0
        |=> o_power_mode == PWR_SLEEP)
        else $error("sleep mode not entered");
    chk_edge_trigger: assert property (
        o_power_mode == PWR_NORMAL && cfg.ctrl2[ARC_EDGE_BIT]
        && $stable(cfg.ctrl1) && $stable(cfg.ctrl2)
        && $rose(i_trig_pin) |=> o_sample_strobe)
        else $error("edge trigger missed");
    cov_normal_strobe: cover property (
        o_power_mode == PWR_NORMAL && o_sample_strobe);
endmodule // arc_rate_timing

// File: logic/arc_highpass_ctrl.sv
// high-pass filter mode, corner and reset control
`timescale 1ns/1ps
module arc_highpass_ctrl
    import arc_pkg::*;
(
    input  wire logic   i_mclk,          // system clock
    input  wire logic   i_reset,         // async reset, high
    arc_cfg_if.user     cfg,             // configuration
    input  wire logic   i_int_event,     // interrupt event pulse
    output logic        o_hp_active,     // filter in signal path
    output logic        o_hp_use_ref,    // reference-signal mode
    output logic        o_hp_reset,      // filter reset pulse
    output logic [3:0]  o_hp_corner,     // effective corner code
    output logic [16:0] o_hp_corner_mhz  // corner in mHz
);
    logic        active_next;
    logic        use_ref_next;
    logic        reset_next;
    logic [3:0]  corner_next;
    logic [16:0] mhz_next;
    logic [1:0]  hp_type;
    logic [3:0]  idx;

    function automatic logic [16:0] corner_mhz(input logic [3:0] i);
        unique case (i)
            4'h0:    corner_mhz = 17'd51400;
            4'h1:    corner_mhz = 17'd27000;
            4'h2:    corner_mhz = 17'd13500;
            4'h3:    corner_mhz = 17'd7200;
            4'h4:    corner_mhz = 17'd3500;
            4'h5:    corner_mhz = 17'd1800;
            4'h6:    corner_mhz = 17'd900;
            4'h7:    corner_mhz = 17'd450;
            4'h8:    corner_mhz = 17'd180;
            4'h9:    corner_mhz = 17'd90;
            4'ha:    corner_mhz = 17'd45;
            4'hb:    corner_mhz = 17'd18;
            default: corner_mhz = 17'd9;
        endcase
    endfunction

    always_comb begin
        hp_type = cfg.ctrl2[ARC_HPTYPE_MSB:ARC_HPTYPE_LSB];
        active_next = cfg.hp_on;
        corner_next =
            (cfg.ctrl2[ARC_CORNER_MSB:ARC_CORNER_LSB] > ARC_CORNER_MAX)
            ? ARC_CORNER_MAX
            : cfg.ctrl2[ARC_CORNER_MSB:ARC_CORNER_LSB];
        // higher rate shifts the same corner code to a higher frequency
        idx = corner_next + 4'h3
              - {2'h0, cfg.ctrl1[ARC_RATE_MSB:ARC_RATE_LSB]};
        mhz_next = corner_mhz(idx);
        use_ref_next = active_next
                       && hp_type == ARC_HPTYPE_REFERENCE;
        reset_next = active_next &&
            ((hp_type == ARC_HPTYPE_NORMAL_RST && cfg.ref_read)
             || (hp_type == ARC_HPTYPE_AUTORESET
                 && i_int_event));
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_hp_active     <= ARC_RST_HP_ON;
            o_hp_use_ref    <= 1'b0;
            o_hp_reset      <= 1'b0;
            o_hp_corner     <= 4'h0;
            o_hp_corner_mhz <= 17'd7200;
        end else begin
            o_hp_active     <= active_next;
            o_hp_use_ref    <= use_ref_next;
            o_hp_reset      <= reset_next;
            o_hp_corner     <= corner_next;
            o_hp_corner_mhz <= mhz_next;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    chk_autoreset_event: assert property (
        cfg.hp_on && cfg.ctrl2[5:4] == 2'h3 && i_int_event
        |=> o_hp_reset)
        else $error("autoreset missed interrupt event");
    chk_normal_no_reset: assert property (
        cfg.ctrl2[5:4] == 2'h2 |=> !o_hp_reset)
        else $error("filter reset in plain normal mode");
    chk_corner_clamp: assert property (
        cfg.ctrl2[3:0] > 4'h9 |=> o_hp_corner == 4'h9)
        else $error("undefined corner code not clamped");
    cov_autoreset: cover property (o_hp_reset && o_hp_active);
endmodule // arc_highpass_ctrl

// File: logic/arc_gyro_regs.sv
// angular-rate channel identity and control register file
// What this block does
// - fixed read-only identity byte, writes ignored
// - control one: rate, band, power, axis enables
// - rate code selects 95/190/380/760 Hz sampling
// - band and rate codes select low-pass cutoff
// - power bit clear forces power-down
// - powered, no axes: sleep; else normal
// - axis enables reset to one, gate axes
// - control two: triggers, high-pass type, corner
// - edge trigger enable resets off, gates trigger
// - level trigger enable resets off, gates trigger
// - type 00 resets on reference read; 10 not
// - type 01 filters against stored reference
// - type 11 autoresets filter on interrupt event
// - corner code with rate selects cutoff
// - filter bypassed unless its enable set
// - reference register, read/write, resets zero
`timescale 1ns/1ps
module arc_gyro_regs
    import arc_pkg::*;
#(
    parameter logic [7:0] IDENTITY = 8'h5a,   // arbitrary value
    parameter int         BASE_DIV = ARC_BASE_DIV
) (
    input  wire logic   i_mclk,          // system clock, 125 MHz
    input  wire logic   i_reset,         // async reset, high
    input  wire logic   i_wr_en,         // register write strobe
    input  wire logic   i_rd_en,         // register read strobe
    input  wire logic [7:0] i_addr,      // register address
    input  wire logic [7:0] i_wdata,     // write data
    output logic [7:0]  o_rdata,         // read data
    output logic        o_rd_valid,      // pulse: read data valid
    input  wire logic   i_trig_pin,      // external trigger pin
    input  wire logic   i_int_event,     // interrupt event pulse
    output arc_pwr_t    o_power_mode,    // down, sleep, normal
    output logic [2:0]  o_axis_on,       // z,x,y measuring
    output logic        o_sample_strobe, // sample pulse
    output logic [9:0]  o_cutoff_dhz,    // low-pass in 0.1 Hz
    output logic        o_hp_active,     // high-pass in path
    output logic        o_hp_use_ref,    // reference mode
    output logic        o_hp_reset,      // high-pass reset pulse
    output logic [3:0]  o_hp_corner,     // effective corner code
    output logic [16:0] o_hp_corner_mhz, // high-pass corner, mHz
    output logic [7:0]  o_reference      // stored reference
);
    arc_cfg_if cfg ();

    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl1_next;
    logic [7:0] ctrl2_reg;
    logic [7:0] ctrl2_next;
    logic       hp_on_reg;
    logic       hp_on_next;
    logic [7:0] ref_reg;
    logic [7:0] ref_next;
    logic [7:0] rdata_next;

    always_comb begin
        ctrl1_next = ctrl1_reg;
        ctrl2_next = ctrl2_reg;
        hp_on_next = hp_on_reg;
        ref_next   = ref_reg;
        if (i_wr_en) begin
            unique case (i_addr)
                ARC_ADDR_CTRL1:     ctrl1_next = i_wdata;
                ARC_ADDR_CTRL2:     ctrl2_next = i_wdata;
                ARC_ADDR_FILT_EN:   hp_on_next = i_wdata[ARC_HPON_BIT];
                ARC_ADDR_REFERENCE: ref_next   = i_wdata;
                default: ;  // identity and unmapped: no effect
            endcase
        end
        unique case (i_addr)
            ARC_ADDR_IDENTITY:  rdata_next = IDENTITY;
            ARC_ADDR_CTRL1:     rdata_next = ctrl1_reg;
            ARC_ADDR_CTRL2:     rdata_next = ctrl2_reg;
            ARC_ADDR_FILT_EN:   rdata_next = 8'(hp_on_reg) << ARC_HPON_BIT;
            ARC_ADDR_REFERENCE: rdata_next = ref_reg;
            default:            rdata_next = ARC_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ctrl1_reg   <= ARC_RST_CTRL1;
            ctrl2_reg   <= ARC_RST_CTRL2;
            hp_on_reg   <= ARC_RST_HP_ON;
            ref_reg     <= ARC_RST_REFERENCE;
            o_rdata     <= 8'h00;
            o_rd_valid  <= 1'b0;
            o_reference <= ARC_RST_REFERENCE;
        end else begin
            ctrl1_reg   <= ctrl1_next;
            ctrl2_reg   <= ctrl2_next;
            hp_on_reg   <= hp_on_next;
            ref_reg     <= ref_next;
            o_rdata     <= i_rd_en ? rdata_next : o_rdata;
            o_rd_valid  <= i_rd_en;
            o_reference <= ref_next;
        end
    end

    assign cfg.ctrl1    = ctrl1_reg;
    assign cfg.ctrl2    = ctrl2_reg;
    assign cfg.hp_on    = hp_on_reg;
    assign cfg.ref_read = i_rd_en && i_addr == ARC_ADDR_REFERENCE;

    arc_rate_timing #(
        .BASE_DIV (BASE_DIV)
    ) u_rate (
        .i_mclk          (i_mclk),
        .i_reset         (i_reset),
        .cfg             (cfg.user),
        .i_trig_pin      (i_trig_pin),
        .o_power_mode    (o_power_mode),
        .o_axis_on       (o_axis_on),
        .o_sample_strobe (o_sample_strobe),
        .o_cutoff_dhz    (o_cutoff_dhz)
    );

    arc_highpass_ctrl u_hp (
        .i_mclk          (i_mclk),
        .i_reset         (i_reset),
        .cfg             (cfg.user),
        .i_int_event     (i_int_event),
        .o_hp_active     (o_hp_active),
        .o_hp_use_ref    (o_hp_use_ref),
        .o_hp_reset      (o_hp_reset),
        .o_hp_corner     (o_hp_corner),
        .o_hp_corner_mhz (o_hp_corner_mhz)
    );

    // helper: strobe spacing while the configuration stays untouched
    logic        cfg_same;
    logic        same_reg;
    logic        steady_reg;
    logic        steady_next;
    logic [23:0] gap_reg;
    logic [23:0] gap_next;

    always_comb begin
        cfg_same    = ctrl1_next == ctrl1_reg && ctrl2_next == ctrl2_reg;
        steady_next = (o_sample_strobe ? same_reg : steady_reg) && cfg_same;
        gap_next    = o_sample_strobe ? 24'h1 : gap_reg + 24'h1;
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            same_reg   <= 1'b0;
            steady_reg <= 1'b0;
            gap_reg    <= 24'h0;
        end else begin
            same_reg   <= cfg_same;
            steady_reg <= steady_next;
            gap_reg    <= gap_next;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    chk_identity_read: assert property (
        i_rd_en && i_addr == 8'h0f |=> o_rd_valid && o_rdata == IDENTITY)
        else $error("identity read wrong");
    chk_ctrl1_write: assert property (
        i_wr_en && i_addr == 8'h20 ##1 i_rd_en && i_addr == 8'h20 && !i_wr_en
        |=> o_rdata == $past(i_wdata, 2))
        else $error("control one readback wrong");
    chk_ctrl2_write: assert property (
        i_wr_en && i_addr == 8'h21 |=> ctrl2_reg == $past(i_wdata))
        else $error("control two not stored");
    chk_ref_read_reset: assert property (
        hp_on_reg && ctrl2_reg[5:4] == 2'h0 && i_rd_en && i_addr == 8'h25
        |=> o_hp_reset && o_rd_valid)
        else $error("reference read did not reset filter");
    chk_rate_period: assert property (
        o_sample_strobe && steady_reg && ctrl2_reg[7:6] == 2'h0
        |-> gap_reg == 24'(BASE_DIV) >> ctrl1_reg[7:6])
        else $error("sample period does not match rate code");
    chk_cutoff_760: assert property (
        ctrl1_reg[7:4] == 4'hf |=> o_cutoff_dhz == 10'd1000)
        else $error("cutoff at 760 Hz band 11 wrong");
    chk_hp_bypass: assert property (
        !hp_on_reg |=> !o_hp_active && !o_hp_reset && !o_hp_use_ref)
        else $error("high-pass active while disabled");
    chk_ref_mode: assert property (
        hp_on_reg && ctrl2_reg[5:4] == 2'h1 |=> o_hp_use_ref)
        else $error("reference mode not selected");
    chk_axis_gate: assert property (
        ctrl1_reg[3] && ctrl1_reg[2:0] != 3'h0
        |=> o_axis_on == $past(ctrl1_reg[2:0]))
        else $error("axis enables not applied");
    chk_ref_store: assert property (
        i_wr_en && i_addr == 8'h25 |=> o_reference == $past(i_wdata))
        else $error("reference not stored");
    chk_corner_code: assert property (
        ctrl2_reg[3:0] == 4'h0 && ctrl1_reg[7:6] == 2'h0
        |=> o_hp_corner_mhz == 17'd7200)
        else $error("corner 0000 at 95 Hz wrong");
    cov_identity: cover property (o_rd_valid && o_rdata == IDENTITY);
endmodule // arc_gyro_regs

// File: bench/arc_gyro_regs_bench.sv
// self-checking bench for the angular-rate configuration registers
`timescale 1ns/1ps
module arc_gyro_regs_bench;
    import arc_pkg::*;
    localparam int         DIV = 64;
    localparam logic [7:0] ID  = 8'h3c;  // arbitrary value

    logic        i_mclk      = 1'b0;
    logic        i_reset     = 1'b1;
    logic        i_wr_en     = 1'b0;
    logic        i_rd_en     = 1'b0;
    logic        i_trig_pin  = 1'b0;
    logic        i_int_event = 1'b0;
    logic [7:0]  i_addr      = 8'h00;
    logic [7:0]  i_wdata     = 8'h00;
    logic [7:0]  o_rdata;
    logic        o_rd_valid;
    arc_pwr_t    o_power_mode;
    logic [2:0]  o_axis_on;
    logic        o_sample_strobe;
    logic [9:0]  o_cutoff_dhz;
    logic        o_hp_active;
    logic        o_hp_use_ref;
    logic        o_hp_reset;
    logic [3:0]  o_hp_corner;
    logic [16:0] o_hp_corner_mhz;
    logic [7:0]  o_reference;
    logic        hp_rst_seen;
    int          miscompares = 0;
    int          n_checks    = 0;

    always #4 i_mclk = ~i_mclk;

    arc_gyro_regs #(.IDENTITY(ID), .BASE_DIV(DIV)) arc_gyro_regs_i (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
        .i_trig_pin(i_trig_pin), .i_int_event(i_int_event),
        .o_power_mode(o_power_mode), .o_axis_on(o_axis_on),
        .o_sample_strobe(o_sample_strobe), .o_cutoff_dhz(o_cutoff_dhz),
        .o_hp_active(o_hp_active), .o_hp_use_ref(o_hp_use_ref),
        .o_hp_reset(o_hp_reset), .o_hp_corner(o_hp_corner),
        .o_hp_corner_mhz(o_hp_corner_mhz), .o_reference(o_reference)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [16:0] seen,
                       input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr_en <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr_en <= 1'b0;
    endtask

    // derived outputs follow one cycle after the write edge
    task automatic settle();
        repeat (3) @(posedge i_mclk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_rd_en <= 1'b1;
        i_addr  <= a;
        @(posedge i_mclk);
        i_rd_en <= 1'b0;
        #1;
        hp_rst_seen = o_hp_reset;
        chk("rd_valid", {16'h0, o_rd_valid}, 17'h1);
        chk($sformatf("reg %h", a), {9'h0, o_rdata}, {9'h0, exp});
    endtask

    task automatic count_strobes(input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc) begin
            @(posedge i_mclk);
            #1;
            if (o_sample_strobe === 1'b1) cnt++;
        end
    endtask

    task automatic wait_strobe(input int max, output int n);
        n = 0;
        do begin
            @(posedge i_mclk);
            #1;
            n++;
        end while (o_sample_strobe !== 1'b1 && n < max);
        if (o_sample_strobe !== 1'b1) begin
            miscompares++;
            $display("ERROR sample strobe expected 1 seen none");
            tally_and_finish();
        end
    endtask

    task automatic pulse_int(output int cnt);
        @(posedge i_mclk);
        i_int_event <= 1'b1;
        @(posedge i_mclk);
        i_int_event <= 1'b0;
        cnt = 0;
        repeat (3) begin
            #1;
            if (o_hp_reset === 1'b1) cnt++;
            @(posedge i_mclk);
        end
    endtask

    // write, then read the same address on the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr_en <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b1;
        @(posedge i_mclk);
        i_rd_en <= 1'b0;
        #1;
        chk("rd_valid", {16'h0, o_rd_valid}, 17'h1);
        chk("readback", {9'h0, o_rdata}, {9'h0, d});
    endtask

    task automatic t_reset();
        rd(ARC_ADDR_IDENTITY, ID);
        rd(ARC_ADDR_CTRL1, 8'h07);
        rd(ARC_ADDR_CTRL2, 8'h00);
        rd(ARC_ADDR_FILT_EN, 8'h00);
        rd(ARC_ADDR_REFERENCE, 8'h00);
        chk("mode", {15'h0, o_power_mode}, {15'h0, PWR_DOWN});
        chk("hp_active", {16'h0, o_hp_active}, 17'h0);
        chk("corner_mhz", o_hp_corner_mhz, 17'd7200);
        $display("test reset done");
    endtask

    task automatic t_access();
        wr(ARC_ADDR_IDENTITY, 8'hff);
        rd(ARC_ADDR_IDENTITY, ID);
        rd(8'h33, 8'h00);
        wr(ARC_ADDR_REFERENCE, 8'ha5);
        rd(ARC_ADDR_REFERENCE, 8'ha5);
        wr(ARC_ADDR_CTRL2, 8'h3f);
        rd(ARC_ADDR_CTRL2, 8'h3f);
        settle();
        chk("reference", {9'h0, o_reference}, 17'ha5);
        chk("corner", {13'h0, o_hp_corner}, 17'h9);
        chk("corner_mhz", o_hp_corner_mhz, 17'd9);
        wr(ARC_ADDR_CTRL2, 8'h00);
        $display("test access done");
    endtask

    task automatic t_modes();
        int cnt;
        wr_rd(ARC_ADDR_CTRL1, 8'h8f);
        settle();
        chk("mode", {15'h0, o_power_mode}, {15'h0, PWR_NORMAL});
        chk("axis", {14'h0, o_axis_on}, 17'h7);
        chk("cutoff", {7'h0, o_cutoff_dhz}, 17'd200);
        wr(ARC_ADDR_CTRL1, 8'hdf);
        settle();
        chk("cutoff", {7'h0, o_cutoff_dhz}, 17'd350);
        wr(ARC_ADDR_CTRL1, 8'h08);
        settle();
        chk("mode", {15'h0, o_power_mode}, {15'h0, PWR_SLEEP});
        count_strobes(100, cnt);
        chk("sleep strobes", 17'(cnt), 17'h0);
        wr(ARC_ADDR_CTRL1, 8'h0a);
        settle();
        chk("axis", {14'h0, o_axis_on}, 17'h2);
        wr(ARC_ADDR_CTRL1, 8'h07);
        settle();
        chk("mode", {15'h0, o_power_mode}, {15'h0, PWR_DOWN});
        chk("axis", {14'h0, o_axis_on}, 17'h0);
        $display("test modes done");
    endtask

    task automatic t_rates();
        int n;
        int cut [4] = '{250, 700, 1000, 1000};
        int mhz [4] = '{7200, 13500, 27000, 51400};
        for (int r = 0; r < 4; r++) begin
            wr(ARC_ADDR_CTRL1, {r[1:0], 6'h3f});
            settle();
            chk("cutoff", {7'h0, o_cutoff_dhz}, 17'(cut[r]));
            chk("corner_mhz", o_hp_corner_mhz, 17'(mhz[r]));
            wait_strobe(300, n);
            wait_strobe(300, n);
            chk("period", 17'(n), 17'(DIV >> r));
        end
        $display("test rates done");
    endtask

    task automatic t_highpass();
        int cnt;
        wr(ARC_ADDR_FILT_EN, 8'h10);
        settle();
        chk("hp_active", {16'h0, o_hp_active}, 17'h1);
        rd(ARC_ADDR_REFERENCE, 8'ha5);
        chk("ref read reset", {16'h0, hp_rst_seen}, 17'h1);
        wr(ARC_ADDR_CTRL2, 8'h20);
        settle();
        rd(ARC_ADDR_REFERENCE, 8'ha5);
        chk("ref read reset", {16'h0, hp_rst_seen}, 17'h0);
        wr(ARC_ADDR_CTRL2, 8'h10);
        settle();
        chk("use_ref", {16'h0, o_hp_use_ref}, 17'h1);
        wr(ARC_ADDR_CTRL2, 8'h30);
        settle();
        pulse_int(cnt);
        chk("autoreset", 17'(cnt), 17'h1);
        wr(ARC_ADDR_FILT_EN, 8'h00);
        settle();
        chk("hp_active", {16'h0, o_hp_active}, 17'h0);
        pulse_int(cnt);
        chk("autoreset off", 17'(cnt), 17'h0);
        $display("test highpass done");
    endtask

    task automatic t_trigger();
        int cnt;
        wr(ARC_ADDR_CTRL1, 8'h0f);
        wr(ARC_ADDR_CTRL2, 8'h80);
        settle();
        count_strobes(100, cnt);
        chk("edge idle", 17'(cnt), 17'h0);
        @(posedge i_mclk);
        i_trig_pin <= 1'b1;
        count_strobes(3, cnt);
        chk("edge strobe", 17'(cnt), 17'h1);
        count_strobes(100, cnt);
        chk("edge held", 17'(cnt), 17'h0);
        @(posedge i_mclk);
        i_trig_pin <= 1'b0;
        wr(ARC_ADDR_CTRL2, 8'h40);
        settle();
        count_strobes(150, cnt);
        chk("level low", 17'(cnt), 17'h0);
        @(posedge i_mclk);
        i_trig_pin <= 1'b1;
        count_strobes(150, cnt);
        chk("level high", 17'(cnt > 0), 17'h1);
        @(posedge i_mclk);
        i_trig_pin <= 1'b0;
        wr(ARC_ADDR_CTRL2, 8'h00);
        $display("test trigger done");
    endtask

    initial begin
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_reset();
        t_access();
        t_modes();
        t_rates();
        t_highpass();
        t_trigger();
        tally_and_finish();
    end
endmodule // arc_gyro_regs_bench
